// File: rtl/port_timing_pkg.sv
// Shared constants and types for the per-port tree-state and timing register bank
package port_timing_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_TREE_POINTER = 12'hB01;
    localparam logic [11:0] IDX_TREE_STATE = 12'hB04;
    localparam logic [11:0] IDX_RX_LATENCY = 12'hC00;
    localparam logic [11:0] IDX_TX_LATENCY = 12'hC02;
    localparam logic [11:0] IDX_ASYMMETRY = 12'hC04;
    localparam logic [11:0] IDX_REQ_STAMP_HI = 12'hC08;
    localparam logic [11:0] IDX_REQ_STAMP_LO = 12'hC0A;
    localparam logic [11:0] IDX_SYNC_STAMP_HI = 12'hC0C;
    localparam logic [11:0] IDX_SYNC_STAMP_LO = 12'hC0E;
    localparam logic [11:0] IDX_RESP_STAMP_HI = 12'hC10;
    localparam logic [11:0] IDX_RESP_STAMP_LO = 12'hC12;
    localparam logic [11:0] IDX_STAMP_STATUS = 12'hC14;
    localparam logic [11:0] IDX_STAMP_MASK = 12'hC16;

    // Field layout
    localparam int TREE_COUNT = 8;
    localparam int PTR_W = 3;
    localparam int BIT_TX_ENABLE = 2;
    localparam int BIT_RX_ENABLE = 1;
    localparam int BIT_LEARN_DISABLE = 0;
    localparam int BIT_ASYM_SIGN = 15;
    localparam int ASYM_MAG_W = 15;
    localparam int BIT_SYNC_READY = 15;
    localparam int BIT_REQ_READY = 14;
    localparam int BIT_RESP_READY = 13;
    localparam int CORR_FRAC_BITS = 16;

    // Reset values
    localparam logic [7:0] RST_TREE_POINTER = 8'h00;
    localparam logic [2:0] RST_TREE_STATE = 3'h6;
    localparam logic [15:0] RST_RX_LATENCY = 16'h019F;
    localparam logic [15:0] RST_TX_LATENCY = 16'h002D;
    localparam logic [15:0] RST_ASYMMETRY = 16'h0000;
    localparam logic [15:0] RST_STAMP_FLAGS = 16'h0000;
    localparam logic [15:0] STAMP_FLAG_MASK = 16'hE000;

    typedef enum logic [2:0] {
        MSG_SYNC,
        MSG_DELAY_REQ,
        MSG_PDELAY_REQ,
        MSG_PDELAY_RESP,
        MSG_OTHER
    } ptp_msg_t;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic learn_disable;
    } tree_state_t;

    typedef struct packed {
        logic valid;
        ptp_msg_t msg;
        logic [31:0] time_ns;
    } egress_stamp_t;

    typedef struct packed {
        logic valid;
        logic ingress;
        ptp_msg_t msg;
        logic [63:0] field;
    } correction_t;

endpackage : port_timing_pkg

// File: rtl/port_mstp_ptp_timing_regs.sv
// Per-port spanning-tree state and PTP timing register bank with Avalon-MM slave
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1 - A 3-bit pointer picks which of eight tree instances the state register reaches.
// RULE2 - Eight independent tree-state copies, each read and written through the pointer.
// RULE3 - Bit 2 of an instance enables transmit; cleared blocks egress; resets to one.
// RULE4 - Bit 1 of an instance enables receive; cleared blocks ingress; resets to one.
// RULE5 - Bit 0 of an instance stops source-address learning when set; resets to zero.
// RULE6 - Sixteen-bit read/write receive latency in ns, reset 415.
// RULE7 - Sixteen-bit read/write transmit latency in ns, reset 45.
// RULE8 - Asymmetry bit 15 is a sign: one negative, zero positive.
// RULE9 - Signed asymmetry is added to correction of ingress Sync and Pdelay_Resp.
// RULE10 - Signed asymmetry is subtracted from correction of egress Delay_Req and Pdelay_Req.
// RULE11 - Read-only 32-bit egress stamp of last request, high and low words, reset zero.
// RULE12 - Read-only 32-bit egress stamp of last Sync, as high and low words.
// RULE13 - Read-only 32-bit egress stamp of last Pdelay_Resp, as high and low words.
// RULE14 - New egress stamp sets its status flag; software clears by writing one.
// RULE15 - Both words of a stamp are captured together in one cycle.
module port_mstp_ptp_timing_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave, word addressed
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Forwarding lookup of tree-state gates
    input wire logic [port_timing_pkg::PTR_W-1:0] lookup_tree,
    output port_timing_pkg::tree_state_t lookup_gates,
    // Latency values to the timestamp units
    output logic [15:0] receive_latency_ns,
    output logic [15:0] transmit_latency_ns,
    // Correction field adjustment
    input wire port_timing_pkg::correction_t corr_in,
    output port_timing_pkg::correction_t corr_out,
    // Egress timestamp capture
    input wire port_timing_pkg::egress_stamp_t egress_stamp,
    // Interrupt
    output logic irq
);
    import port_timing_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then a one-cycle acknowledge
    logic ack_r;
    logic bus_req;
    logic wr_en;
    logic [ADDR_W-1:0] idx;

    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_r;
    assign wr_en = avs_write & ack_r;
    assign idx = avs_address;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = old;
        if (be[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction : merge16

    //////////////////////////////////////////////////////////////////////////
    // Tree instance pointer and state copies
    logic [7:0] tree_pointer_r;
    tree_state_t tree_state_r [TREE_COUNT];
    logic [PTR_W-1:0] sel;

    assign sel = tree_pointer_r[PTR_W-1:0]; // RULE1

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tree_pointer_r <= RST_TREE_POINTER;
        end else if (wr_en && idx == IDX_TREE_POINTER && avs_byteenable[0]) begin
            // Upper bits are read/write scratch, kept as written
            tree_pointer_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < TREE_COUNT; i++) begin
                tree_state_r[i] <= RST_TREE_STATE; // RULE3 RULE4 RULE5
            end
        end else if (wr_en && idx == IDX_TREE_STATE && avs_byteenable[0]) begin
            tree_state_r[sel].tx_enable <= avs_writedata[BIT_TX_ENABLE]; // RULE2 RULE3
            tree_state_r[sel].rx_enable <= avs_writedata[BIT_RX_ENABLE]; // RULE4
            tree_state_r[sel].learn_disable <= avs_writedata[BIT_LEARN_DISABLE]; // RULE5
        end
    end

    // Datapath sees the instance its frame belongs to, one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lookup_gates <= RST_TREE_STATE;
        end else begin
            lookup_gates <= tree_state_r[lookup_tree]; // RULE3 RULE4 RULE5
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Latency and asymmetry registers
    logic [15:0] asymmetry_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            receive_latency_ns <= RST_RX_LATENCY; // RULE6
            transmit_latency_ns <= RST_TX_LATENCY; // RULE7
            asymmetry_r <= RST_ASYMMETRY;
        end else if (wr_en) begin
            if (idx == IDX_RX_LATENCY) begin
                receive_latency_ns <= merge16(receive_latency_ns, avs_writedata, avs_byteenable); // RULE6
            end
            if (idx == IDX_TX_LATENCY) begin
                transmit_latency_ns <= merge16(transmit_latency_ns, avs_writedata, avs_byteenable); // RULE7
            end
            if (idx == IDX_ASYMMETRY) begin
                asymmetry_r <= merge16(asymmetry_r, avs_writedata, avs_byteenable);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Correction field adjustment; field carries ns scaled by 2^16
    function automatic logic [63:0] asym_scaled(input logic [15:0] a);
        logic [63:0] mag;
        mag = {33'h0, a[ASYM_MAG_W-1:0], 16'h0};
        asym_scaled = a[BIT_ASYM_SIGN] ? (64'h0 - mag) : mag; // RULE8
    endfunction : asym_scaled

    logic [63:0] asym_delta;
    logic corr_add;
    logic corr_sub;

    assign asym_delta = asym_scaled(asymmetry_r);
    assign corr_add = corr_in.ingress && (corr_in.msg == MSG_SYNC || corr_in.msg == MSG_PDELAY_RESP);
    assign corr_sub = !corr_in.ingress && (corr_in.msg == MSG_DELAY_REQ || corr_in.msg == MSG_PDELAY_REQ);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            corr_out <= '0;
        end else begin
            corr_out.valid <= corr_in.valid;
            corr_out.ingress <= corr_in.ingress;
            corr_out.msg <= corr_in.msg;
            if (corr_add) begin
                corr_out.field <= corr_in.field + asym_delta; // RULE9
            end else if (corr_sub) begin
                corr_out.field <= corr_in.field - asym_delta; // RULE10
            end else begin
                corr_out.field <= corr_in.field;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Egress timestamps, whole 32 bits latched in one edge so halves never tear
    logic [31:0] req_stamp_r;
    logic [31:0] sync_stamp_r;
    logic [31:0] resp_stamp_r;
    logic cap_sync;
    logic cap_req;
    logic cap_resp;

    assign cap_sync = egress_stamp.valid && egress_stamp.msg == MSG_SYNC;
    assign cap_req = egress_stamp.valid && (egress_stamp.msg == MSG_DELAY_REQ || egress_stamp.msg == MSG_PDELAY_REQ);
    assign cap_resp = egress_stamp.valid && egress_stamp.msg == MSG_PDELAY_RESP;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_stamp_r <= 32'h0000_0000; // RULE11
            sync_stamp_r <= 32'h0000_0000;
            resp_stamp_r <= 32'h0000_0000;
        end else begin
            if (cap_req) begin
                req_stamp_r <= egress_stamp.time_ns; // RULE11 RULE15
            end
            if (cap_sync) begin
                sync_stamp_r <= egress_stamp.time_ns; // RULE12 RULE15
            end
            if (cap_resp) begin
                resp_stamp_r <= egress_stamp.time_ns; // RULE13 RULE15
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Stamp-ready flags, write-one-to-clear; a capture in the clear cycle wins
    logic [15:0] stamp_status_r;
    logic [15:0] stamp_mask_r;
    logic [15:0] stamp_set;
    logic [15:0] stamp_clr;
    logic [15:0] stamp_status_nxt;
    logic [15:0] stamp_mask_nxt;
    logic sync_stamp_ready_flag;

    always_comb begin
        stamp_set = 16'h0000;
        stamp_set[BIT_SYNC_READY] = cap_sync;
        stamp_set[BIT_REQ_READY] = cap_req;
        stamp_set[BIT_RESP_READY] = cap_resp;
    end

    assign stamp_clr = (wr_en && idx == IDX_STAMP_STATUS) ? merge16(16'h0000, avs_writedata, avs_byteenable) : 16'h0000;

    assign stamp_status_nxt = ((stamp_status_r & ~stamp_clr) | stamp_set) & STAMP_FLAG_MASK; // RULE14

    always_comb begin
        stamp_mask_nxt = stamp_mask_r;
        if (wr_en && idx == IDX_STAMP_MASK) begin
            stamp_mask_nxt = merge16(stamp_mask_r, avs_writedata, avs_byteenable) & STAMP_FLAG_MASK;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stamp_status_r <= RST_STAMP_FLAGS;
        end else begin
            stamp_status_r <= stamp_status_nxt; // RULE14
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stamp_mask_r <= RST_STAMP_FLAGS;
        end else begin
            stamp_mask_r <= stamp_mask_nxt;
        end
    end

    assign sync_stamp_ready_flag = stamp_status_r[BIT_SYNC_READY];

    // Built from next values, so a mask write shows at the same edge as the register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stamp_status_nxt & stamp_mask_nxt); // RULE14
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read mux, registered in the wait cycle; unmapped reads return zero
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            IDX_TREE_POINTER: rd_mux = {24'h0, tree_pointer_r};
            IDX_TREE_STATE: rd_mux = {29'h0, tree_state_r[sel]}; // RULE1 RULE2
            IDX_RX_LATENCY: rd_mux = {16'h0, receive_latency_ns};
            IDX_TX_LATENCY: rd_mux = {16'h0, transmit_latency_ns};
            IDX_ASYMMETRY: rd_mux = {16'h0, asymmetry_r};
            IDX_REQ_STAMP_HI: rd_mux = {16'h0, req_stamp_r[31:16]}; // RULE11
            IDX_REQ_STAMP_LO: rd_mux = {16'h0, req_stamp_r[15:0]};
            IDX_SYNC_STAMP_HI: rd_mux = {16'h0, sync_stamp_r[31:16]}; // RULE12
            IDX_SYNC_STAMP_LO: rd_mux = {16'h0, sync_stamp_r[15:0]};
            IDX_RESP_STAMP_HI: rd_mux = {16'h0, resp_stamp_r[31:16]}; // RULE13
            IDX_RESP_STAMP_LO: rd_mux = {16'h0, resp_stamp_r[15:0]};
            IDX_STAMP_STATUS: rd_mux = {16'h0, stamp_status_r};
            IDX_STAMP_MASK: rd_mux = {16'h0, stamp_mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_wait_one_cycle: assert property ($rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest) // Bus handshake
        else $error("waitrequest did not drop after one cycle");

    chk_state_via_ptr: assert property (wr_en && idx == IDX_TREE_STATE && avs_byteenable[0]
        |=> tree_state_r[$past(sel)] == $past(avs_writedata[2:0])) // RULE2
        else $error("tree state write missed the pointed instance");

    chk_state_readback: assert property (avs_read && !ack_r && idx == IDX_TREE_STATE
        |=> avs_readdata == {29'h0, tree_state_r[$past(sel)]}) // RULE1
        else $error("tree state read not from pointed instance");

    chk_tx_gate_path: assert property (##1 lookup_gates.tx_enable == $past(tree_state_r[lookup_tree].tx_enable)) // RULE3
        else $error("transmit gate does not follow its instance");

    chk_rx_learn_path: assert property (##1 lookup_gates.rx_enable == $past(tree_state_r[lookup_tree].rx_enable)
        && lookup_gates.learn_disable == $past(tree_state_r[lookup_tree].learn_disable)) // RULE4
        else $error("receive or learn gate does not follow its instance");

    chk_learn_hold: assert property (!(wr_en && idx == IDX_TREE_STATE)
        |=> tree_state_r[0].learn_disable == $past(tree_state_r[0].learn_disable)) // RULE5
        else $error("learning disable changed without a write");

    chk_rx_lat_write: assert property (wr_en && idx == IDX_RX_LATENCY && avs_byteenable[1:0] == 2'b11
        |=> receive_latency_ns == $past(avs_writedata[15:0])) // RULE6
        else $error("receive latency write lost");

    chk_tx_lat_write: assert property (wr_en && idx == IDX_TX_LATENCY && avs_byteenable[1:0] == 2'b11
        |=> transmit_latency_ns == $past(avs_writedata[15:0])) // RULE7
        else $error("transmit latency write lost");

    chk_ingress_add: assert property (corr_add |=> corr_out.field == $past(corr_in.field) + $past(asym_delta)) // RULE9
        else $error("ingress correction not added");

    chk_egress_sub: assert property (corr_sub |=> corr_out.field == $past(corr_in.field) - $past(asym_delta)) // RULE10
        else $error("egress correction not subtracted");

    chk_asym_sign: assert property (asymmetry_r[BIT_ASYM_SIGN] && asymmetry_r[14:0] != 15'h0
        |-> asym_delta[63]) // RULE8
        else $error("negative asymmetry not negative");

    chk_req_capture: assert property (cap_req |=> req_stamp_r == $past(egress_stamp.time_ns)) // RULE11
        else $error("request stamp not captured");

    chk_sync_capture: assert property (cap_sync |=> sync_stamp_r == $past(egress_stamp.time_ns)
        && sync_stamp_ready_flag) // RULE12
        else $error("sync stamp or flag not captured");

    chk_resp_capture: assert property (cap_resp |=> resp_stamp_r == $past(egress_stamp.time_ns)) // RULE13
        else $error("response stamp not captured");

    chk_flag_set_wins: assert property (cap_req && stamp_clr[BIT_REQ_READY]
        |=> stamp_status_r[BIT_REQ_READY]) // RULE14
        else $error("flag lost against a clear");

    chk_stamp_atomic: assert property (!cap_sync |=> $stable(sync_stamp_r)) // RULE15
        else $error("sync stamp changed without capture");

    chk_irq_level: assert property (irq == |(stamp_status_r & stamp_mask_r)) // RULE14
        else $error("interrupt does not follow unmasked flags");

    chk_flag_clear: assert property (stamp_clr[BIT_SYNC_READY] && !cap_sync // RULE14
        |=> !stamp_status_r[BIT_SYNC_READY])
        else $error("sync flag not cleared by a written one");

    chk_resp_flag_set: assert property (cap_resp |=> stamp_status_r[BIT_RESP_READY]) // RULE14
        else $error("response flag not set on capture");

    chk_other_passes: assert property (!corr_add && !corr_sub |=> corr_out.field == $past(corr_in.field)) // RULE10
        else $error("correction changed for a message left alone");

    chk_asym_positive: assert property (!asymmetry_r[BIT_ASYM_SIGN] // RULE8
        |-> asym_delta == {33'h0, asymmetry_r[ASYM_MAG_W-1:0], 16'h0})
        else $error("positive asymmetry not the scaled magnitude");

    chk_pointer_readback: assert property (avs_read && !ack_r && idx == IDX_TREE_POINTER // RULE1
        |=> avs_readdata == {24'h0, $past(tree_pointer_r)})
        else $error("pointer read back wrong");

    chk_state_upper_zero: assert property (avs_read && !ack_r && idx == IDX_TREE_STATE // RULE2
        |=> avs_readdata[31:3] == 29'h0)
        else $error("unused tree state bits not zero");

endmodule : port_mstp_ptp_timing_regs

// File: testbench/tb.sv
// Self-checking testbench for the per-port tree-state and timing register bank
`timescale 1ns/1ps

module tb;
    import port_timing_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [PTR_W-1:0] lookup_tree = 3'h0;
    tree_state_t lookup_gates;
    logic [15:0] receive_latency_ns;
    logic [15:0] transmit_latency_ns;
    correction_t corr_in = '0;
    correction_t corr_out;
    egress_stamp_t egress_stamp = '0;
    logic irq;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] read_q[$];
    correction_t corr_q[$];
    logic [2:0] states[TREE_COUNT];
    logic [11:0] rst_addr[13] = '{IDX_TREE_POINTER, IDX_TREE_STATE, IDX_RX_LATENCY, IDX_TX_LATENCY, IDX_ASYMMETRY,
        IDX_REQ_STAMP_HI, IDX_REQ_STAMP_LO, IDX_SYNC_STAMP_HI, IDX_SYNC_STAMP_LO, IDX_RESP_STAMP_HI,
        IDX_RESP_STAMP_LO, IDX_STAMP_STATUS, IDX_STAMP_MASK};
    logic [15:0] rst_val[13] = '{16'h0000, 16'h0006, 16'h019F, 16'h002D, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    port_mstp_ptp_timing_regs uut (
        .core_clk(core_clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .lookup_tree(lookup_tree),
        .lookup_gates(lookup_gates),
        .receive_latency_ns(receive_latency_ns),
        .transmit_latency_ns(transmit_latency_ns),
        .corr_in(corr_in),
        .corr_out(corr_out),
        .egress_stamp(egress_stamp),
        .irq(irq)
    );

    always #5 core_clk = ~core_clk;

    //////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp_word

    task automatic cmp_corr(input correction_t e, input correction_t g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp_corr

    task automatic cmp_small(input logic [2:0] e, input logic [2:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp_small

    // Request held until the edge that sees waitrequest low, then released
    task automatic bus(input logic [11:0] a, input logic wr_en, input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        bus(a, 1'b1, d, be);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        read_q.push_back(e);
        bus(a, 1'b0, 32'h00000000, 4'hF);
    endtask : rd

    //////////////////////////////////////////////////////////////////////////////
    // Outputs taken at the edge that ends the transfer
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && read_q.size() > 0) begin
            cmp_word(read_q.pop_front(), avs_readdata);
        end
        if (corr_out.valid === 1'b1 && corr_q.size() > 0) begin
            cmp_corr(corr_q.pop_front(), corr_out);
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            print_verdict();
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] t;
        logic [15:0] v;
        logic [14:0] mag;
        logic [11:0] hi;
        logic [15:0] flag;
        logic [63:0] adj;
        correction_t c;
        correction_t e;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        void'($urandom(79));
        for (int i = 0; i < 13; i++) begin
            rd(rst_addr[i], {16'h0000, rst_val[i]});
        end
        cmp_word(32'h0000019F, {16'h0000, receive_latency_ns});
        cmp_word(32'h0000002D, {16'h0000, transmit_latency_ns});
        wr(12'hC06, 32'h0000FFFF);
        rd(12'hC06, 32'h00000000);
        // Every instance starts from reset, then gets its own value
        for (int i = 0; i < TREE_COUNT; i++) begin
            states[i] = 3'($urandom());
            wr(IDX_TREE_POINTER, 32'(i));
            rd(IDX_TREE_STATE, 32'h00000006);
            wr(IDX_TREE_STATE, {24'h000000, 5'h1F, states[i]});
        end
        // Scratch bits above the pointer must not disturb the selection
        for (int i = 0; i < TREE_COUNT; i++) begin
            t = {24'h000000, 5'($urandom()), 3'(i)};
            wr(IDX_TREE_POINTER, t);
            rd(IDX_TREE_POINTER, t);
            rd(IDX_TREE_STATE, {29'h0, states[i]});
            @(posedge core_clk);
            lookup_tree <= 3'(i);
            @(posedge core_clk);
            @(negedge core_clk);
            cmp_small(states[i], lookup_gates);
        end
        v = 16'($urandom());
        wr(IDX_RX_LATENCY, {16'h0000, v});
        rd(IDX_RX_LATENCY, {16'h0000, v});
        cmp_word({16'h0000, v}, {16'h0000, receive_latency_ns});
        wr(IDX_TX_LATENCY, 32'h0000ABCD);
        wr(IDX_TX_LATENCY, 32'h00001234, 4'h2);
        rd(IDX_TX_LATENCY, 32'h000012CD);
        cmp_word(32'h000012CD, {16'h0000, transmit_latency_ns});
        // Both signs, every message kind in both directions, back to back
        for (int s = 0; s < 2; s++) begin
            mag = 15'($urandom());
            wr(IDX_ASYMMETRY, {16'h0000, s[0], mag});
            rd(IDX_ASYMMETRY, {16'h0000, s[0], mag});
            adj = {33'h0, mag, 16'h0000};
            if (s == 1) begin
                adj = -adj;
            end
            for (int m = 0; m < 5; m++) begin
                for (int g = 0; g < 2; g++) begin
                    c = '{1'b1, g[0], ptp_msg_t'(m), {$urandom(), $urandom()}};
                    e = c;
                    if (g == 1 && (m == 0 || m == 3)) begin
                        e.field = c.field + adj;
                    end
                    if (g == 0 && (m == 1 || m == 2)) begin
                        e.field = c.field - adj;
                    end
                    corr_q.push_back(e);
                    @(posedge core_clk);
                    corr_in <= c;
                end
            end
            @(posedge core_clk);
            corr_in <= '0;
        end
        // Stamp capture, flag, mask and clear for each kind of egress message
        for (int m = 0; m < 4; m++) begin
            wr(IDX_STAMP_MASK, (m == 1) ? 32'h00000000 : 32'h0000E000);
            rd(IDX_STAMP_MASK, (m == 1) ? 32'h00000000 : 32'h0000E000);
            t = $urandom();
            @(posedge core_clk);
            egress_stamp <= '{1'b1, ptp_msg_t'(m), t};
            @(posedge core_clk);
            egress_stamp <= '0;
            hi = (m == 0) ? IDX_SYNC_STAMP_HI : (m == 3) ? IDX_RESP_STAMP_HI : IDX_REQ_STAMP_HI;
            flag = (m == 0) ? 16'h8000 : (m == 3) ? 16'h2000 : 16'h4000;
            wr(hi, 32'h0000FFFF);
            rd(hi, {16'h0000, t[31:16]});
            rd(hi + 12'h002, {16'h0000, t[15:0]});
            rd(IDX_STAMP_STATUS, {16'h0000, flag});
            @(negedge core_clk);
            cmp_small({2'b00, m != 1}, {2'b00, irq});
            if (m == 1) begin
                wr(IDX_STAMP_MASK, 32'h0000E000);
                @(negedge core_clk);
                cmp_small(3'h1, {2'b00, irq});
            end
            wr(IDX_STAMP_STATUS, {16'h0000, flag});
            rd(IDX_STAMP_STATUS, 32'h00000000);
            @(negedge core_clk);
            cmp_small(3'h0, {2'b00, irq});
        end
        // A capture in the very cycle of a clear keeps its flag
        t = $urandom();
        fork
            wr(IDX_STAMP_STATUS, 32'h00004000);
            begin
                repeat (2) @(posedge core_clk);
                egress_stamp <= '{1'b1, MSG_DELAY_REQ, t};
                @(posedge core_clk);
                egress_stamp <= '0;
            end
        join
        rd(IDX_REQ_STAMP_LO, {16'h0000, t[15:0]});
        rd(IDX_STAMP_STATUS, 32'h00004000);
        @(negedge core_clk);
        cmp_small(3'h1, {2'b00, irq});
        repeat (4) @(posedge core_clk);
        print_verdict();
    end
endmodule : tb
